// file: verilog/lcc_defs.vh
`ifndef LCC_DEFS_VH
`define LCC_DEFS_VH

// ****************************************************************
// Register byte offsets on the bus
// ****************************************************************
`define LCC_OFF_CTRL 8'h00
`define LCC_OFF_STATUS 8'h04
`define LCC_OFF_BUS 8'h08

// ****************************************************************
// Control register field positions
// ****************************************************************
`define LCC_CTRL_CNT_MODE 0
`define LCC_CTRL_AMODE_LO 1
`define LCC_CTRL_AMODE_HI 3
`define LCC_CTRL_CHIP_RST_EN 4
`define LCC_CTRL_USED_HI 4

// ****************************************************************
// Reset values
// ****************************************************************
`define LCC_CTRL_RESET 5'h00
`define LCC_PIN_IDLE 1'b1

// ****************************************************************
// Counter modes
// ****************************************************************
`define LCC_CNT_UPDOWN 1'b0
`define LCC_CNT_CLEARABLE 1'b1

// ****************************************************************
// Asynchronous clear, preset and load modes
// ****************************************************************
`define LCC_AM_CLR 3'h0
`define LCC_AM_PRE 3'h1
`define LCC_AM_CLR_PRE 3'h2
`define LCC_AM_LD_CLR 3'h3
`define LCC_AM_LD_PRE 3'h4
`define LCC_AM_LD_ONLY 3'h5

// ****************************************************************
// Bus encodings
// ****************************************************************
`define LCC_HTRANS_NONSEQ 2'h2
`define LCC_HRESP_OKAY 1'b0

`endif

// file: verilog/lcc_cell.v
`timescale 1ns/10ps
`default_nettype none

module lcc_cell (
  input wire clk,
  input wire srst,
  input wire cnt_mode,
  input wire [2:0] async_mode,
  input wire chip_rst,
  input wire ctrl_first,
  input wire ctrl_second,
  input wire carry_in,
  input wire up_down,
  input wire sync_clear,
  input wire sync_load,
  input wire load_bit,
  input wire clk_en,
  input wire async_bit,
  output wire q,
  output wire carry_out
);

`include "lcc_defs.vh"

  reg st_r;
  reg st_nxt;
  reg set_a;
  reg clr_a;
  wire inv;
  wire dir;
  wire sum_lut;
  wire load_mux;
  wire d_true;
  wire ld_pre_val;

  // ****************************************************************
  // Count path
  // ****************************************************************

  // Preset and load-preset modes keep the bit inverted so a clear presets it
  assign inv = (async_mode == `LCC_AM_PRE) | (async_mode == `LCC_AM_LD_PRE); // RQ15
  assign q = st_r ^ inv;
  // Clearable mode only counts up
  assign dir = (cnt_mode == `LCC_CNT_CLEARABLE) ? 1'b1 : up_down; // RQ6
  // Bit function of feedback and carry; carry function of feedback, carry and direction
  assign sum_lut = q ^ carry_in; // RQ3 RQ2
  assign carry_out = carry_in & ~(q ^ dir); // RQ3 RQ1
  assign load_mux = sync_load ? load_bit : sum_lut; // RQ4
  assign d_true = (cnt_mode == `LCC_CNT_CLEARABLE) ? (load_mux & ~sync_clear) : load_mux; // RQ7
  assign ld_pre_val = ~async_bit; // RQ19

  // ****************************************************************
  // Asynchronous control decode, in stored polarity
  // ****************************************************************
  always @*
  begin
    set_a = 1'b0;
    clr_a = 1'b0;
    case (async_mode)
      `LCC_AM_CLR:
      begin
        clr_a = ctrl_first | ctrl_second; // RQ13
      end
      `LCC_AM_PRE:
      begin
        clr_a = ctrl_first; // RQ15 RQ16
      end
      `LCC_AM_CLR_PRE:
      begin
        set_a = ctrl_first; // RQ17
        clr_a = ctrl_second; // RQ17
      end
      `LCC_AM_LD_CLR:
      begin
        set_a = ctrl_first & async_bit; // RQ18 RQ14
        clr_a = (ctrl_first & ~async_bit) | ctrl_second; // RQ18
      end
      `LCC_AM_LD_PRE:
      begin
        set_a = ctrl_first & ld_pre_val; // RQ19 RQ14
        clr_a = (ctrl_first & ~ld_pre_val) | ctrl_second; // RQ19
      end
      `LCC_AM_LD_ONLY:
      begin
        set_a = ctrl_first & async_bit; // RQ20 RQ14
        clr_a = ctrl_first & ~async_bit; // RQ20
      end
      default:
      begin
        set_a = 1'b0;
        clr_a = 1'b0;
      end
    endcase
  end

  // Next stored value: chip reset, then clear, then set, then clocked
  always @*
  begin
    st_nxt = st_r;
    if (chip_rst)
      st_nxt = 1'b0; // RQ11 RQ12
    else if (clr_a)
      st_nxt = 1'b0; // RQ5
    else if (set_a)
      st_nxt = 1'b1; // RQ5
    else if (clk_en)
      st_nxt = d_true ^ inv; // RQ21
  end

  // Cell register
  always @(posedge clk)
  begin
    if (srst)
      st_r <= 1'b0;
    else
      st_r <= st_nxt;
  end

endmodule

`default_nettype wire

// file: verilog/lcc_top.v
`timescale 1ns/10ps
`default_nettype none

// Function
// RQ1 - Up/down counter with enables, direction, load
// RQ2 - Controls from data, carry-in, register feedback
// RQ3 - Two three-input functions: bit and carry
// RQ4 - Two-way selector gives synchronous load
// RQ5 - Clear and preset also load register
// RQ6 - Clearable mode: synchronous clear replaces direction
// RQ7 - Selector output ANDed with synchronous clear
// RQ8 - Emulated bus: contention low, idle high
// RQ9 - Clear/preset active low, unused held high
// RQ10 - Six asynchronous clear/preset/load modes
// RQ11 - Enabled chip reset overrides every control
// RQ12 - Preset registers may go one on reset
// RQ13 - Clear mode: either line clears register
// RQ14 - Load modes: first line copies load value
// RQ15 - Preset as tied-high load or inverted clear
// RQ16 - Inverted-clear preset leaves load input free
// RQ17 - Clear-preset: first sets, second clears
// RQ18 - Load-clear: first loads, second clears only
// RQ19 - Load-preset: second presets, load data inverted
// RQ20 - Load-only: first line steers both paths
// RQ21 - Clock enable blocks updates when inactive
// RQ22 - Chained counter wraps modulo two power width

module lcc_top #(
  parameter WIDTH = 8,
  parameter BUS_W = 8,
  parameter NDRV = 4
) (
  input wire clk,
  input wire srst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire [31:0] hrdata,
  output wire hresp,
  input wire count_enable,
  input wire clock_enable_source,
  input wire up_down,
  input wire sync_clear,
  input wire sync_load,
  input wire [WIDTH-1:0] load_data,
  input wire [WIDTH-1:0] async_load_value_in,
  input wire block_ctrl_first_n,
  input wire block_ctrl_second_n,
  input wire chip_reset_n,
  input wire [NDRV*BUS_W-1:0] drv_data,
  input wire [NDRV-1:0] drv_oe,
  output wire [WIDTH-1:0] count_value,
  output wire carry_out,
  output wire [BUS_W-1:0] tri_bus_value
);

`include "lcc_defs.vh"

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg [`LCC_CTRL_USED_HI:0] ctrl_r;
  reg [`LCC_CTRL_USED_HI:0] ctrl_nxt;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  reg [31:0] hrdata_r;
  reg [31:0] rd_nxt;
  reg hreadyout_r;
  reg [2:0] first_sync_r;
  reg [2:0] second_sync_r;
  reg [2:0] chip_sync_r;
  reg first_n_r;
  reg second_n_r;
  reg chip_n_r;
  reg [WIDTH-1:0] count_r;
  reg carry_r;
  reg [BUS_W-1:0] bus_r;
  reg [BUS_W-1:0] bus_nxt;
  wire addr_ok;
  wire [7:0] addr_lo;
  wire cnt_mode;
  wire [2:0] async_mode;
  wire chip_rst;
  wire [WIDTH:0] carry;
  wire [WIDTH-1:0] q_vec;
  wire [NDRV:0] oe_any;
  wire [NDRV:0] oe_many;
  wire [BUS_W-1:0] drv_or [0:NDRV];

  // ****************************************************************
  // Bus slave
  // ****************************************************************

  // Address phase taken on a selected, ready NONSEQ transfer
  assign addr_ok = hsel & hready & (htrans == `LCC_HTRANS_NONSEQ);
  assign addr_lo = haddr[7:0];

  // Control register write from the data phase
  always @*
  begin
    ctrl_nxt = ctrl_r;
    if (wr_pend_r && (wr_addr_r == `LCC_OFF_CTRL))
      ctrl_nxt = hwdata[`LCC_CTRL_USED_HI:0];
  end

  // Read data for the coming data phase, forwarding a pending write
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    case (addr_lo)
      `LCC_OFF_CTRL:
      begin
        rd_nxt[`LCC_CTRL_USED_HI:0] = ctrl_nxt;
      end
      `LCC_OFF_STATUS:
      begin
        rd_nxt[WIDTH-1:0] = count_r;
        rd_nxt[WIDTH] = carry_r;
      end
      `LCC_OFF_BUS:
      begin
        rd_nxt[BUS_W-1:0] = bus_r;
      end
      default:
      begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Bus state: pending write, read data, control register
  always @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_r <= `LCC_CTRL_RESET;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      hreadyout_r <= 1'b1;
      wr_pend_r <= addr_ok & hwrite;
      if (addr_ok)
        wr_addr_r <= {addr_lo[7:2], 2'b00};
      if (addr_ok && !hwrite)
        hrdata_r <= rd_nxt;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = `LCC_HRESP_OKAY;

  // Configuration fields
  assign cnt_mode = ctrl_r[`LCC_CTRL_CNT_MODE];
  assign async_mode = ctrl_r[`LCC_CTRL_AMODE_HI:`LCC_CTRL_AMODE_LO]; // RQ10

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // Three stages; a change counts once the last two agree
  always @(posedge clk)
  begin
    if (srst)
    begin
      first_sync_r <= {3{`LCC_PIN_IDLE}};
      second_sync_r <= {3{`LCC_PIN_IDLE}};
      chip_sync_r <= {3{`LCC_PIN_IDLE}};
      first_n_r <= `LCC_PIN_IDLE; // RQ9
      second_n_r <= `LCC_PIN_IDLE; // RQ9
      chip_n_r <= `LCC_PIN_IDLE;
    end
    else
    begin
      first_sync_r <= {first_sync_r[1:0], block_ctrl_first_n};
      second_sync_r <= {second_sync_r[1:0], block_ctrl_second_n};
      chip_sync_r <= {chip_sync_r[1:0], chip_reset_n};
      if (first_sync_r[1] == first_sync_r[2])
        first_n_r <= first_sync_r[2];
      if (second_sync_r[1] == second_sync_r[2])
        second_n_r <= second_sync_r[2];
      if (chip_sync_r[1] == chip_sync_r[2])
        chip_n_r <= chip_sync_r[2];
    end
  end

  // Chip reset acts only when software enabled it
  assign chip_rst = ctrl_r[`LCC_CTRL_CHIP_RST_EN] & ~chip_n_r; // RQ11

  // ****************************************************************
  // Counter chain
  // ****************************************************************

  // Count enable enters as the carry of the lowest cell
  assign carry[0] = count_enable; // RQ1

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_cell
      lcc_cell u_cell (
        .clk(clk),
        .srst(srst),
        .cnt_mode(cnt_mode),
        .async_mode(async_mode),
        .chip_rst(chip_rst),
        .ctrl_first(~first_n_r),
        .ctrl_second(~second_n_r),
        .carry_in(carry[gi]),
        .up_down(up_down),
        .sync_clear(sync_clear),
        .sync_load(sync_load),
        .load_bit(load_data[gi]),
        .clk_en(clock_enable_source),
        .async_bit(async_load_value_in[gi]),
        .q(q_vec[gi]),
        .carry_out(carry[gi+1])
      );
    end
  endgenerate

  // Registered copies of the count and the top carry
  always @(posedge clk)
  begin
    if (srst)
    begin
      count_r <= {WIDTH{1'b0}};
      carry_r <= 1'b0;
    end
    else
    begin
      count_r <= q_vec; // RQ22
      carry_r <= carry[WIDTH];
    end
  end

  assign count_value = count_r;
  assign carry_out = carry_r;

  // ****************************************************************
  // Emulated internal bus
  // ****************************************************************

  // Running OR of enabled drivers plus any and several flags
  assign oe_any[0] = 1'b0;
  assign oe_many[0] = 1'b0;
  assign drv_or[0] = {BUS_W{1'b0}};

  genvar gd;
  generate
    for (gd = 0; gd < NDRV; gd = gd + 1)
    begin : g_drv
      assign oe_any[gd+1] = oe_any[gd] | drv_oe[gd];
      assign oe_many[gd+1] = oe_many[gd] | (oe_any[gd] & drv_oe[gd]);
      assign drv_or[gd+1] = drv_or[gd] | (drv_data[gd*BUS_W +: BUS_W] & {BUS_W{drv_oe[gd]}});
    end
  endgenerate

  // Contention reads low, no driver reads high
  always @*
  begin
    bus_nxt = drv_or[NDRV];
    if (oe_many[NDRV])
      bus_nxt = {BUS_W{1'b0}}; // RQ8
    else if (!oe_any[NDRV])
      bus_nxt = {BUS_W{1'b1}}; // RQ8
  end

  // Resolved bus register
  always @(posedge clk)
  begin
    if (srst)
      bus_r <= {BUS_W{1'b1}};
    else
      bus_r <= bus_nxt;
  end

  assign tri_bus_value = bus_r;

endmodule

`default_nettype wire

// file: tb/lcc_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module lcc_top_sva #(
  parameter WIDTH = 8,
  parameter BUS_W = 8,
  parameter NDRV = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic count_enable,
  input wire logic clock_enable_source,
  input wire logic up_down,
  input wire logic sync_clear,
  input wire logic sync_load,
  input wire logic [WIDTH-1:0] load_data,
  input wire logic block_ctrl_first_n,
  input wire logic block_ctrl_second_n,
  input wire logic chip_reset_n,
  input wire logic [NDRV*BUS_W-1:0] drv_data,
  input wire logic [NDRV-1:0] drv_oe,
  input wire logic [WIDTH-1:0] count_value,
  input wire logic [BUS_W-1:0] tri_bus_value
);
  // ****
  // Helpers
  // ****
  logic [3:0] quiet_r;
  logic [1:0] up_r, ld_r, hold_r;
  logic [WIDTH-1:0] ldv1_r, ldv2_r;
  logic [BUS_W-1:0] bus_exp;
  // Quiet time: no pin, write or reset; inputs delayed to output timing
  always_ff @(posedge clk)
  begin
    if (srst || !(block_ctrl_first_n && block_ctrl_second_n && chip_reset_n)
        || (hsel && hready && htrans == 2'h2 && hwrite))
      quiet_r <= 4'h0;
    else if (quiet_r != 4'hf)
      quiet_r <= quiet_r + 4'h1;
    up_r <= {up_r[0], clock_enable_source & count_enable & up_down & !sync_load & !sync_clear};
    ld_r <= {ld_r[0], clock_enable_source & sync_load & !sync_clear};
    hold_r <= {hold_r[0], !clock_enable_source};
    ldv1_r <= load_data;
    ldv2_r <= ldv1_r;
  end
  // Expected bus resolution
  always_comb
  begin
    bus_exp = '1;
    for (int i = 0; i < NDRV; i++)
      if (drv_oe[i])
        bus_exp = drv_data[i*BUS_W +: BUS_W];
    if ($countones(drv_oe) > 1)
      bus_exp = '0;
  end
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  ready_up_a: assert property (!$past(srst) |-> hreadyout)
    else $error("hreadyout low after reset");
  reset_val_a: assert property (disable iff (1'b0)
    srst |=> (count_value == '0) && (tri_bus_value == '1))
    else $error("reset values wrong");
  bus_resolve_a: assert property (!$past(srst) |-> tri_bus_value == $past(bus_exp))
    else $error("bus resolution wrong");
  sync_load_a: assert property (quiet_r == 4'hf && ld_r[1] |-> count_value == ldv2_r)
    else $error("load value not taken");
  count_up_a: assert property (quiet_r == 4'hf && up_r[1] |-> count_value == $past(count_value) + 1'b1)
    else $error("count up wrong");
  ce_hold_a: assert property (quiet_r == 4'hf && hold_r[1] |-> $stable(count_value))
    else $error("count moved with enable low");
  unmapped_rd_a: assert property (hsel && hready && htrans == 2'h2 && !hwrite
    && haddr[7:0] > 8'h08 |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule
bind lcc_top lcc_top_sva #(.WIDTH(WIDTH), .BUS_W(BUS_W), .NDRV(NDRV)) i_lcc_top_sva (
  .clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp,
  .count_enable, .clock_enable_source, .up_down, .sync_clear, .sync_load, .load_data,
  .block_ctrl_first_n, .block_ctrl_second_n, .chip_reset_n, .drv_data, .drv_oe,
  .count_value, .tri_bus_value);
`default_nettype wire

// file: tb/lcc_far_logic.sv
`timescale 1ns/10ps
`default_nettype none
module lcc_far_logic (
  input wire logic clk,
  input wire logic [2:0] req,
  output logic first_n = 1'b1,
  output logic second_n = 1'b1,
  output logic chip_n = 1'b1
);
  // Control lines sit high unless asked low
  always @(posedge clk)
  begin
    {chip_n, second_n, first_n} <= ~req;
  end
endmodule
`default_nettype wire

// file: tb/test_logic_cell_counter_async_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module test_logic_cell_counter_async_ctrl;
  logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
  logic [1:0] htrans = 2'h0;
  logic count_enable = 1'b0, clock_enable_source = 1'b0, up_down = 1'b1;
  logic sync_clear = 1'b0, sync_load = 1'b0;
  logic [7:0] load_data = 8'h00, async_load_value_in = 8'ha5;
  logic [31:0] drv_data = 32'h4433_2211;
  logic [3:0] drv_oe = 4'h0;
  logic [2:0] req = 3'h0;
  wire logic hready, hreadyout, hresp, first_n, second_n, chip_n;
  wire logic [31:0] hrdata;
  wire logic [7:0] count_value, tri_bus_value;
  int failures = 0, n_tests = 0, cyc = 0;
  // Rows: control word, pin request (chip, second, first), value expected
  logic [15:0] arow [13] = '{{5'h00, 3'h1, 8'h00}, {5'h02, 3'h1, 8'hff},
    {5'h04, 3'h1, 8'hff}, {5'h06, 3'h1, 8'ha5}, {5'h08, 3'h1, 8'ha5},
    {5'h0a, 3'h1, 8'ha5}, {5'h00, 3'h2, 8'h00}, {5'h04, 3'h2, 8'h00},
    {5'h06, 3'h2, 8'h00}, {5'h08, 3'h2, 8'hff}, {5'h04, 3'h3, 8'h00},
    {5'h1a, 3'h5, 8'h00}, {5'h12, 3'h4, 8'hff}};
  // Rows: driver enables, resolved bus
  logic [11:0] brow [6] = '{{4'h0, 8'hff}, {4'h1, 8'h11}, {4'h4, 8'h33},
    {4'h8, 8'h44}, {4'h3, 8'h00}, {4'hf, 8'h00}};
  assign hready = hreadyout;
  lcc_top i_lcc_top (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hreadyout, .hrdata, .hresp, .count_enable, .clock_enable_source,
    .up_down, .sync_clear, .sync_load, .load_data, .async_load_value_in,
    .block_ctrl_first_n(first_n), .block_ctrl_second_n(second_n), .chip_reset_n(chip_n),
    .drv_data, .drv_oe, .count_value, .carry_out(), .tri_bus_value);
  lcc_far_logic i_lcc_far_logic (.clk, .req, .first_n, .second_n, .chip_n);
  // ****
  // Tasks
  // ****
  initial forever #2 clk = ~clk;
  task conclude;
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One single bus transfer; read data lands in rd
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  task load(input logic [7:0] v);
    @(posedge clk);
    sync_load <= 1'b1;
    load_data <= v;
    @(posedge clk);
    sync_load <= 1'b0;
  endtask
  task run(input logic up, input int n, input logic [7:0] e);
    @(posedge clk);
    up_down <= up;
    count_enable <= 1'b1;
    tick(n);
    count_enable <= 1'b0;
    tick(2);
    chk("count", 32'(count_value), 32'(e));
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      conclude;
    end
  end
  // ****
  // Sequence
  // ****
  initial
  begin
    tick(8);
    srst <= 1'b0;
    tick(2);
    xfer(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl", rd, 32'h0000_0000);
    foreach (brow[i])
    begin
      @(posedge clk);
      drv_oe <= brow[i][11:8];
      tick(2);
      chk("bus", 32'(tri_bus_value), 32'(brow[i][7:0]));
    end
    xfer(1'b0, 8'h08, 32'h0000_0000);
    chk("bus reg", rd, 32'h0000_0000);
    clock_enable_source <= 1'b1;
    load(8'hfe);
    run(1'b1, 3, 8'h01);
    run(1'b0, 3, 8'hfe);
    clock_enable_source <= 1'b0;
    run(1'b1, 2, 8'hfe);
    xfer(1'b0, 8'h04, 32'h0000_0000);
    chk("status", {24'h00_0000, rd[7:0]}, 32'h0000_00fe);
    xfer(1'b1, 8'h00, 32'h0000_0001);
    clock_enable_source <= 1'b1;
    load(8'h10);
    run(1'b0, 2, 8'h12);
    @(posedge clk);
    sync_clear <= 1'b1;
    sync_load <= 1'b1;
    @(posedge clk);
    sync_clear <= 1'b0;
    sync_load <= 1'b0;
    tick(2);
    chk("clear", 32'(count_value), 32'h0000_0000);
    xfer(1'b0, 8'h0c, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    foreach (arow[i])
    begin
      xfer(1'b1, 8'h00, {27'h000_0000, arow[i][15:11]});
      @(posedge clk);
      req <= arow[i][10:8];
      tick(10);
      chk("async", 32'(count_value), 32'(arow[i][7:0]));
      req <= 3'h0;
      tick(10);
    end
    conclude;
  end
endmodule
`default_nettype wire
